// ### rtl/cir_irq_regs.sv
/*
  Status, clear and enable registers with the read port and the
  interrupt output. Assumes one-cycle strobes, never both at once.
*/
`include "cir_regs.svh"
module cir_irq_regs (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire cir_pkg::cir_reg_req_t req,
  input wire logic [`CIR_EV_W-1:0] ev,
  input wire logic [7:0] state_byte,
  input wire logic [7:0] vpage,
  output logic [7:0] rdata,
  output logic irq
);
  logic [`CIR_EV_W-1:0] stat_reg, en_reg, clr_mask;

  assign clr_mask = (req.wr && req.addr == `CIR_OFS_CLEAR) ? req.wdata[`CIR_EV_W-1:0] : '0;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stat_reg <= '0;
    end else begin
      // Set wins over a clear in the same cycle
      stat_reg <= (stat_reg & ~clr_mask) | ev;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      en_reg <= '0;
    end else if (req.wr && req.addr == `CIR_OFS_ENABLE) begin
      en_reg <= req.wdata[`CIR_EV_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_reg & en_reg);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= 8'h00;
      if (req.rd) begin
        unique case (req.addr)
          `CIR_OFS_STATUS: rdata <= 8'(stat_reg);
          `CIR_OFS_ENABLE: rdata <= 8'(en_reg);
          `CIR_OFS_STATE: rdata <= state_byte;
          `CIR_OFS_VPAGE: rdata <= vpage;
          default: rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule : cir_irq_regs

// ### rtl/cir_irq_unit.sv
/*
  Interrupt response sequencer of the processor: enable flip-flops,
  response modes, vector page, acknowledge with wait states, push and
  table read. Assumes the core pulses boundary at each instruction end,
  holds pc and sp stable and stalls while busy is high.
*/
// Chosen here: the plain strobed port and the register offsets.
`include "cir_regs.svh"
// Overview of operation
// [RULE1] A non-maskable request is always taken and restarts at 0066H.
// [RULE2] A restart pushes the return address and jumps into page zero.
// [RULE3] Three maskable response modes; exactly one active.
// [RULE4] Mode zero executes the byte supplied during acknowledge, operands too.
// [RULE5] Mode zero: the peripheral drives the instruction during acknowledge.
// [RULE6] Every acknowledge carries two automatic wait states; the mode zero operand acknowledge (ST_OPND) here has none.
// [RULE7] Reset selects mode zero.
// [RULE8] Mode one restarts at 0038H with the same acknowledge.
// [RULE9] Mode two pointer: vector page above, peripheral byte below.
// [RULE10] Vector page loaded from the accumulator; reset clears it.
// [RULE11] Peripheral's mode two vector byte has a zero low bit.
// [RULE12] Table gives low address byte first, then the high byte.
// [RULE13] Mode two takes 19 clocks: vector 7, push 6, table 6.
// [RULE14] Chained peripherals supply their vector during acknowledge.
// [RULE15] Non-maskable request sampled with maskable; wins and cannot be masked.
// [RULE16] Taking a maskable request clears both enable flip-flops.
// [RULE17] Taking a non-maskable request clears primary, keeps shadow.
// [RULE18] After enable instruction, next instruction completes before acceptance.
// [RULE19] Mode kept in a state field changed only by mode instructions and reset.
module cir_irq_unit (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic nmi_n,
  input wire logic int_n,
  input wire logic boundary,
  input wire logic op_fetch,
  input wire cir_pkg::cir_cmd_t cmd,
  input wire logic [7:0] acc,
  input wire logic [15:0] pc,
  input wire logic [15:0] sp,
  input wire logic [7:0] data_in,
  input wire logic [7:0] mem_rdata,
  input wire cir_pkg::cir_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic irq_out,
  output cir_pkg::cir_mem_req_t mem_req_reg,
  output logic ack_reg,
  output logic ack_wait_reg,
  output logic busy_reg,
  output logic jump_valid_reg,
  output logic [15:0] jump_addr_reg,
  output logic [15:0] sp_new_reg,
  output logic inject_valid_reg,
  output logic [7:0] inject_op_reg
);
  logic [1:0] pin_lvl;
  logic nmi_lvl_reg, nmi_pend_reg, nmi_fall;
  logic primary_irq_enable_ff, shadow_irq_enable_ff;
  cir_pkg::cir_mode_t mode_reg, run_mode_reg;
  logic [7:0] vpage_reg, tab_lo_reg;
  cir_pkg::cir_state_t state_reg;
  logic [3:0] cnt_reg, el_next;
  logic is_nmi_reg, take_nmi, take_irq, idle, cnt_end;
  logic [`CIR_EV_W-1:0] ev_reg;
  logic [15:0] vec_reg;

  function automatic cir_pkg::cir_mem_req_t mop(input logic rd, input logic [15:0] a, input logic [7:0] d);
    mop.rd = rd;
    mop.wr = ~rd;
    mop.addr = a;
    mop.wdata = d;
  endfunction : mop

  cir_sync #(.W(2), .INIT(2'h3)) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin({nmi_n, int_n}),
    .level(pin_lvl)
  );

  cir_irq_regs u_regs (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .req(reg_req),
    .ev(ev_reg),
    .state_byte({2'h0, busy_reg, mode_reg, shadow_irq_enable_ff, primary_irq_enable_ff, nmi_pend_reg}),
    .vpage(vpage_reg),
    .rdata(reg_rdata),
    .irq(irq_out)
  );

  assign idle = state_reg == cir_pkg::ST_IDLE;
  assign cnt_end = cnt_reg == 4'h0;
  assign el_next = `CIR_ACK_CLKS - cnt_reg;
  assign nmi_fall = nmi_lvl_reg & ~pin_lvl[1];
  // Both lines looked at on the same boundary; no enable gates the NMI
  assign take_nmi = idle & boundary & nmi_pend_reg; // [RULE15] [RULE1]
  // DI or EI on this boundary keeps the maskable request out
  assign take_irq = idle & boundary & ~nmi_pend_reg & ~pin_lvl[0] & primary_irq_enable_ff
                    & ~cmd.ei & ~cmd.di; // [RULE18]

  // Edge-latched so a short NMI pulse is not lost during a long sequence
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      nmi_lvl_reg <= 1'b1;
      nmi_pend_reg <= 1'b0;
    end else begin
      nmi_lvl_reg <= pin_lvl[1];
      if (take_nmi) begin
        nmi_pend_reg <= 1'b0;
      end
      if (nmi_fall) begin
        nmi_pend_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      primary_irq_enable_ff <= 1'b0;
      shadow_irq_enable_ff <= 1'b0;
    end else begin
      if (cmd.ei) begin
        primary_irq_enable_ff <= 1'b1;
        shadow_irq_enable_ff <= 1'b1;
      end else if (cmd.di) begin
        primary_irq_enable_ff <= 1'b0;
        shadow_irq_enable_ff <= 1'b0;
      end else if (cmd.retn) begin
        primary_irq_enable_ff <= shadow_irq_enable_ff;
      end
      if (take_nmi) begin
        primary_irq_enable_ff <= 1'b0; // [RULE17]
      end
      if (take_irq) begin
        primary_irq_enable_ff <= 1'b0; // [RULE16]
        shadow_irq_enable_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= cir_pkg::CIR_IM0; // [RULE7]
    end else if (cmd.im0) begin
      mode_reg <= cir_pkg::CIR_IM0; // [RULE19] [RULE3]
    end else if (cmd.im1) begin
      mode_reg <= cir_pkg::CIR_IM1;
    end else if (cmd.im2) begin
      mode_reg <= cir_pkg::CIR_IM2;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      vpage_reg <= `CIR_VPAGE_RESET; // [RULE10]
    end else if (cmd.ld_vpage) begin
      vpage_reg <= acc;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= cir_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      is_nmi_reg <= 1'b0;
      run_mode_reg <= cir_pkg::CIR_IM0;
      vec_reg <= 16'h0000;
      tab_lo_reg <= 8'h00;
      ev_reg <= '0;
      mem_req_reg <= '0;
      ack_reg <= 1'b0;
      ack_wait_reg <= 1'b0;
      busy_reg <= 1'b0;
      jump_valid_reg <= 1'b0;
      jump_addr_reg <= 16'h0000;
      sp_new_reg <= 16'h0000;
      inject_valid_reg <= 1'b0;
      inject_op_reg <= 8'h00;
    end else begin
      mem_req_reg <= '0;
      jump_valid_reg <= 1'b0;
      inject_valid_reg <= 1'b0;
      ev_reg <= '0;
      cnt_reg <= cnt_reg - 4'h1;
      unique case (state_reg)
        cir_pkg::ST_IDLE: begin
          if (take_nmi) begin
            // Fetched opcode is thrown away
            state_reg <= cir_pkg::ST_FETCH;
            cnt_reg <= `CIR_FETCH_CLKS - 4'h1;
            is_nmi_reg <= 1'b1;
            vec_reg <= `CIR_NMI_VECTOR; // [RULE1]
            busy_reg <= 1'b1;
            ev_reg[`CIR_EV_NMI] <= 1'b1;
          end else if (take_irq) begin
            state_reg <= cir_pkg::ST_ACK;
            cnt_reg <= `CIR_ACK_CLKS - 4'h1; // [RULE6]
            is_nmi_reg <= 1'b0;
            run_mode_reg <= mode_reg;
            vec_reg <= `CIR_MODE1_VECTOR; // [RULE8]
            busy_reg <= 1'b1;
            ack_reg <= 1'b1;
            ev_reg[`CIR_EV_IRQ] <= 1'b1;
          end else if (op_fetch) begin
            // Further bytes of an injected instruction also come from the peripheral
            state_reg <= cir_pkg::ST_OPND; // [RULE4]
            cnt_reg <= `CIR_MEM_CLKS - 4'h1;
            busy_reg <= 1'b1;
            ack_reg <= 1'b1;
          end
        end
        cir_pkg::ST_FETCH: begin
          if (cnt_end) begin
            state_reg <= cir_pkg::ST_PUSH_HI;
            cnt_reg <= `CIR_MEM_CLKS - 4'h1;
            mem_req_reg <= mop(1'b0, sp - 16'h0001, pc[15:8]); // [RULE2]
          end
        end
        cir_pkg::ST_ACK: begin
          // Daisy chain settles during the two inserted waits
          ack_wait_reg <= el_next >= `CIR_ACK_WAIT_FIRST
                          && el_next < `CIR_ACK_WAIT_FIRST + `CIR_ACK_WAIT_CLKS; // [RULE6]
          if (cnt_end) begin
            ack_reg <= 1'b0;
            ack_wait_reg <= 1'b0;
            unique case (run_mode_reg)
              cir_pkg::CIR_IM0: begin
                state_reg <= cir_pkg::ST_IDLE;
                busy_reg <= 1'b0;
                inject_valid_reg <= 1'b1; // [RULE4]
                inject_op_reg <= data_in;
              end
              cir_pkg::CIR_IM1: begin
                state_reg <= cir_pkg::ST_PUSH_HI;
                cnt_reg <= `CIR_MEM_CLKS - 4'h1;
                mem_req_reg <= mop(1'b0, sp - 16'h0001, pc[15:8]); // [RULE8]
              end
              cir_pkg::CIR_IM2: begin
                // Odd vector is used as given but flagged to software
                vec_reg <= {vpage_reg, data_in}; // [RULE9] [RULE14]
                ev_reg[`CIR_EV_ODD] <= data_in[0]; // [RULE11]
                state_reg <= cir_pkg::ST_PUSH_HI;
                cnt_reg <= `CIR_MEM_CLKS - 4'h1;
                mem_req_reg <= mop(1'b0, sp - 16'h0001, pc[15:8]);
              end
            endcase
          end
        end
        cir_pkg::ST_OPND: begin
          if (cnt_end) begin
            state_reg <= cir_pkg::ST_IDLE;
            busy_reg <= 1'b0;
            ack_reg <= 1'b0;
            inject_valid_reg <= 1'b1;
            inject_op_reg <= data_in;
          end
        end
        cir_pkg::ST_PUSH_HI: begin
          if (cnt_end) begin
            state_reg <= cir_pkg::ST_PUSH_LO;
            cnt_reg <= `CIR_MEM_CLKS - 4'h1;
            mem_req_reg <= mop(1'b0, sp - 16'h0002, pc[7:0]); // [RULE2]
          end
        end
        cir_pkg::ST_PUSH_LO: begin
          if (cnt_end) begin
            if (!is_nmi_reg && run_mode_reg == cir_pkg::CIR_IM2) begin
              state_reg <= cir_pkg::ST_TAB_LO;
              cnt_reg <= `CIR_MEM_CLKS - 4'h1;
              mem_req_reg <= mop(1'b1, vec_reg, 8'h00); // [RULE12]
            end else begin
              state_reg <= cir_pkg::ST_IDLE;
              busy_reg <= 1'b0;
              jump_valid_reg <= 1'b1;
              jump_addr_reg <= vec_reg;
              sp_new_reg <= sp - 16'h0002;
            end
          end
        end
        cir_pkg::ST_TAB_LO: begin
          if (cnt_reg == `CIR_MEM_CLKS - 4'h2) begin
            tab_lo_reg <= mem_rdata;
          end
          if (cnt_end) begin
            state_reg <= cir_pkg::ST_TAB_HI;
            cnt_reg <= `CIR_MEM_CLKS - 4'h1;
            mem_req_reg <= mop(1'b1, vec_reg + 16'h0001, 8'h00); // [RULE12]
          end
        end
        cir_pkg::ST_TAB_HI: begin
          if (cnt_reg == `CIR_MEM_CLKS - 4'h2) begin
            vec_reg <= {mem_rdata, tab_lo_reg}; // [RULE12]
          end
          if (cnt_end) begin
            state_reg <= cir_pkg::ST_IDLE; // [RULE13]
            busy_reg <= 1'b0;
            jump_valid_reg <= 1'b1;
            jump_addr_reg <= vec_reg;
            sp_new_reg <= sp - 16'h0002;
          end
        end
        default: state_reg <= cir_pkg::ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_push;
    mem_req_reg.wr && mem_req_reg.addr == sp - 16'h0001 ##3 mem_req_reg.wr && mem_req_reg.addr == sp - 16'h0002;
  endsequence
  sequence s_table;
    mem_req_reg.rd && mem_req_reg.addr[15:8] == vpage_reg ##3 mem_req_reg.rd;
  endsequence

  property p_nmi_jump;
    take_nmi |-> ##6 s_push ##3 jump_valid_reg && jump_addr_reg == 16'h0066;
  endproperty
  a_nmi_jump: assert property (p_nmi_jump) else $error("NMI restart wrong"); // [RULE1]
  property p_mode_held;
    !cmd.im0 && !cmd.im1 && !cmd.im2 |=> $stable(mode_reg);
  endproperty
  a_mode_held: assert property (p_mode_held) else $error("Mode changed without a mode command"); // [RULE19] [RULE3]
  property p_mode0_inject;
    take_irq && mode_reg == cir_pkg::CIR_IM0 |-> ##8 inject_valid_reg && inject_op_reg == $past(data_in);
  endproperty
  a_mode0_inject: assert property (p_mode0_inject) else $error("Mode 0 byte not injected"); // [RULE4]
  property p_ack_waits;
    take_irq |=> (ack_reg && !ack_wait_reg) [*2] ##1 (ack_reg && ack_wait_reg) [*2] ##1 ack_reg [*3] ##1 !ack_reg;
  endproperty
  a_ack_waits: assert property (p_ack_waits) else $error("Acknowledge length wrong"); // [RULE6]
  property p_reset_vals;
    !$past(rstn) |-> mode_reg == cir_pkg::CIR_IM0 && vpage_reg == 8'h00 && !primary_irq_enable_ff;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("Reset values wrong"); // [RULE7]
  property p_mode1_jump;
    take_irq && mode_reg == cir_pkg::CIR_IM1 |-> ##8 s_push ##3 jump_valid_reg && jump_addr_reg == 16'h0038;
  endproperty
  a_mode1_jump: assert property (p_mode1_jump) else $error("Mode 1 restart wrong"); // [RULE8]
  property p_mode2_seq;
    take_irq && mode_reg == cir_pkg::CIR_IM2 |-> ##8 s_push ##3 s_table ##3 jump_valid_reg && !busy_reg;
  endproperty
  a_mode2_seq: assert property (p_mode2_seq) else $error("Mode 2 sequence wrong"); // [RULE13]
  property p_nmi_first;
    idle && boundary && nmi_pend_reg |-> !take_irq ##1 state_reg == cir_pkg::ST_FETCH;
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("NMI lost priority"); // [RULE15]
  property p_irq_iff;
    take_irq |=> !primary_irq_enable_ff && !shadow_irq_enable_ff;
  endproperty
  a_irq_iff: assert property (p_irq_iff) else $error("Enables not cleared"); // [RULE16]
  property p_nmi_iff;
    take_nmi && cmd == '0 |=> !primary_irq_enable_ff && shadow_irq_enable_ff == $past(shadow_irq_enable_ff);
  endproperty
  a_nmi_iff: assert property (p_nmi_iff) else $error("NMI enable handling wrong"); // [RULE17]
  property p_ei_hold;
    idle && boundary && cmd.ei && !op_fetch |=> !ack_reg;
  endproperty
  a_ei_hold: assert property (p_ei_hold) else $error("Taken right after EI"); // [RULE18]
endmodule : cir_irq_unit

// ### rtl/cir_pkg.sv
/*
  Types of the interrupt response unit.
  Assumes nothing beyond a SystemVerilog tool.
*/
package cir_pkg;
  typedef enum logic [1:0] {CIR_IM0, CIR_IM1, CIR_IM2} cir_mode_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH, ST_ACK, ST_OPND, ST_PUSH_HI, ST_PUSH_LO, ST_TAB_LO, ST_TAB_HI
  } cir_state_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cir_mem_req_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } cir_reg_req_t;
  typedef struct packed {
    logic ei;
    logic di;
    logic retn;
    logic im0;
    logic im1;
    logic im2;
    logic ld_vpage;
  } cir_cmd_t;
endpackage : cir_pkg

// ### rtl/cir_regs.svh
/*
  Offsets, field positions, reset values and cycle counts of the
  interrupt response unit. Assumes one 100 MHz clock, one T-state per clock.
*/
`ifndef CIR_REGS_SVH
`define CIR_REGS_SVH
`define CIR_NMI_VECTOR 16'h0066
`define CIR_MODE1_VECTOR 16'h0038
`define CIR_VPAGE_RESET 8'h00
`define CIR_FETCH_CLKS 4'h5
`define CIR_ACK_BASE_CLKS 4'h5
`define CIR_ACK_WAIT_CLKS 4'h2
`define CIR_ACK_CLKS (`CIR_ACK_BASE_CLKS + `CIR_ACK_WAIT_CLKS)
`define CIR_ACK_WAIT_FIRST 4'h2
`define CIR_MEM_CLKS 4'h3
`define CIR_OFS_STATUS 4'h0
`define CIR_OFS_CLEAR 4'h1
`define CIR_OFS_ENABLE 4'h2
`define CIR_OFS_STATE 4'h3
`define CIR_OFS_VPAGE 4'h4
`define CIR_EV_NMI 0
`define CIR_EV_IRQ 1
`define CIR_EV_ODD 2
`define CIR_EV_W 3
`define CIR_ST_NMI_PEND 0
`define CIR_ST_PRIMARY_IRQ_ENABLE_FF 1
`define CIR_ST_SHADOW_IRQ_ENABLE_FF 2
`define CIR_ST_MODE 3
`define CIR_ST_BUSY 5
`endif

// ### rtl/cir_sync.sv
/*
  Three-stage pin synchroniser; a change counts once stages two and
  three agree. Assumes pins asynchronous to sys_clk.
*/
module cir_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg;

  if (W < 1) begin : g_w_check
    $error("cir_sync: W must be at least 1");
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        s1_reg[i] <= INIT[i];
        s2_reg[i] <= INIT[i];
        s3_reg[i] <= INIT[i];
        level[i] <= INIT[i];
      end else begin
        s1_reg[i] <= pin[i];
        s2_reg[i] <= s1_reg[i];
        s3_reg[i] <= s2_reg[i];
        if (s2_reg[i] == s3_reg[i]) begin
          level[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule : cir_sync

// ### testbench/cir_irq_unit_tb.sv
/*
  Self-checking bench of the interrupt response unit with a peripheral
  model and a table memory. Assumes one 100 MHz clock.
*/
module cir_irq_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic nmi_n = 1'b1;
  logic irq_req = 1'b0;
  logic slow = 1'b0;
  logic [7:0] vec = 8'h00;
  logic boundary = 1'b0;
  logic op_fetch = 1'b0;
  cir_pkg::cir_cmd_t cmd = '0;
  logic [7:0] acc = 8'h00;
  logic [15:0] pc = 16'h0000;
  logic [15:0] sp = 16'h0000;
  logic [7:0] mem_rdata = 8'h00;
  cir_pkg::cir_reg_req_t reg_req = '0;
  logic int_n, ack_reg, ack_wait_reg, busy_reg, jump_valid_reg, inject_valid_reg, irq_out;
  logic [7:0] data_in, reg_rdata, inject_op_reg, q;
  logic [15:0] jump_addr_reg, sp_new_reg;
  cir_pkg::cir_mem_req_t mem_req_reg;
  logic [23:0] wq[$];
  logic [15:0] rq[$];
  int n_fail = 0;
  int n_tests = 0;
  int n_wait = 0;
  int n_busy = 0;
  int n_ack = 0;
  int seed;

  always #5 sys_clk = ~sys_clk;

  cir_periph_model periph (.sys_clk(sys_clk), .rstn(rstn), .req(irq_req), .slow(slow), .vec(vec),
    .ack(ack_reg), .ack_wait(ack_wait_reg), .int_n(int_n), .data_in(data_in));

  cir_irq_unit uut (.sys_clk(sys_clk), .rstn(rstn), .nmi_n(nmi_n), .int_n(int_n), .boundary(boundary),
    .op_fetch(op_fetch), .cmd(cmd), .acc(acc), .pc(pc), .sp(sp), .data_in(data_in), .mem_rdata(mem_rdata),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .irq_out(irq_out), .mem_req_reg(mem_req_reg),
    .ack_reg(ack_reg), .ack_wait_reg(ack_wait_reg), .busy_reg(busy_reg), .jump_valid_reg(jump_valid_reg),
    .jump_addr_reg(jump_addr_reg), .sp_new_reg(sp_new_reg), .inject_valid_reg(inject_valid_reg),
    .inject_op_reg(inject_op_reg));

  function automatic logic [7:0] tab(input logic [15:0] a);
    return a[7:0] ^ {a[14:8], a[15]} ^ 8'h3C;
  endfunction : tab

  function automatic logic [7:0] st(input logic [1:0] m, input logic sh, input logic pr);
    return {3'b000, m, sh, pr, 1'b0};
  endfunction : st

  // Memory answers the cycle after a read; otherwise the bus churns
  always @(posedge sys_clk) begin
    if (mem_req_reg.wr) wq.push_back({mem_req_reg.addr, mem_req_reg.wdata});
    if (mem_req_reg.rd) rq.push_back(mem_req_reg.addr);
    n_wait += ack_wait_reg;
    n_busy += busy_reg;
    n_ack += ack_reg;
    mem_rdata <= mem_req_reg.rd ? tab(mem_req_reg.addr) : ~mem_rdata;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic op(input logic [6:0] c, input logic b);
    @(posedge sys_clk);
    cmd <= cir_pkg::cir_cmd_t'(c);
    boundary <= b;
    @(posedge sys_clk);
    cmd <= '0;
    boundary <= 1'b0;
  endtask : op

  task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
    @(posedge sys_clk);
    reg_req <= '{rd: !wr, wr: wr, addr: a, wdata: d};
    @(posedge sys_clk);
    reg_req <= '0;
    #1 r = reg_rdata;
  endtask : reg_acc

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] r;
    reg_acc(1'b0, a, 8'h00, r);
    chk(r, exp);
  endtask : rd_chk

  // Kinds: 0 non-maskable, 1..3 modes one, two, zero, 4 operand fetch
  task automatic accept(input int kind, input logic [15:0] ptr);
    int k;
    wq.delete();
    rq.delete();
    n_wait = 0;
    n_busy = 0;
    n_ack = 0;
    @(posedge sys_clk);
    {pc, sp} <= $random(seed);
    boundary <= (kind != 4);
    op_fetch <= (kind == 4);
    @(posedge sys_clk);
    boundary <= 1'b0;
    op_fetch <= 1'b0;
    k = 0;
    do begin
      @(posedge sys_clk);
      #1 k++;
    end while (k < 40 && jump_valid_reg !== 1'b1 && inject_valid_reg !== 1'b1);
    if (kind >= 3) begin
      chk(inject_valid_reg, 1'b1);
      chk(inject_op_reg, vec);
    end else begin
      chk(jump_valid_reg, 1'b1);
      chk(jump_addr_reg, kind == 0 ? 16'h0066 : kind == 1 ? 16'h0038 : {tab(ptr + 16'h1), tab(ptr)});
      chk(sp_new_reg, sp - 16'h2);
      chk(wq.size(), 2);
      if (wq.size() == 2) begin
        chk(wq[0], {sp - 16'h1, pc[15:8]});
        chk(wq[1], {sp - 16'h2, pc[7:0]});
      end
    end
    if (kind != 4) chk(n_wait, kind == 0 ? 0 : 2);
    chk(n_ack, kind == 0 ? 0 : kind == 4 ? 3 : 7);
    if (kind != 2) chk(n_busy, kind == 0 ? 11 : kind == 1 ? 13 : kind == 3 ? 7 : 3);
    if (kind == 2) begin
      chk(n_busy, 19);
      chk(rq.size(), 2);
      if (rq.size() == 2) begin
        chk(rq[0], ptr);
        chk(rq[1], ptr + 16'h1);
      end
    end
    $display("test kind %0d done", kind);
  endtask : accept

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    print_verdict();
  end

  initial begin
    seed = 32'h0EFA0AC3;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    rd_chk(4'h3, st(2'h0, 1'b0, 1'b0));
    rd_chk(4'h4, 8'h00);
    rd_chk(4'hF, 8'h00);
    $display("test reset done");
    op(7'h40, 1'b1);
    irq_req <= 1'b1;
    nmi_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    accept(0, 16'h0000);
    @(posedge sys_clk);
    nmi_n <= 1'b1;
    rd_chk(4'h3, st(2'h0, 1'b1, 1'b0));
    op(7'h04, 1'b1);
    rd_chk(4'h3, st(2'h1, 1'b1, 1'b0));
    op(7'h10, 1'b0);
    rd_chk(4'h3, st(2'h1, 1'b1, 1'b1));
    accept(1, 16'h0000);
    rd_chk(4'h3, st(2'h1, 1'b0, 1'b0));
    // Enables already set, so only the one-instruction delay holds the request off
    op(7'h40, 1'b0);
    op(7'h40, 1'b1);
    #1 chk(busy_reg, 1'b0);
    accept(1, 16'h0000);
    @(posedge sys_clk);
    irq_req <= 1'b0;
    repeat (6) @(posedge sys_clk);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      acc <= 8'($random(seed));
      vec <= {7'($random(seed)), 1'(i)};
      slow <= 1'(i);
      irq_req <= 1'b1;
      op(7'h01, 1'b1);
      op(7'h02, 1'b1);
      rd_chk(4'h4, acc);
      op(7'h40, 1'b1);
      accept(2, {acc, vec});
      @(posedge sys_clk);
      irq_req <= 1'b0;
      repeat (6) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    vec <= {2'b11, 3'($random(seed)), 3'b111};
    slow <= 1'b0;
    irq_req <= 1'b1;
    op(7'h08, 1'b1);
    op(7'h40, 1'b0);
    repeat (4) @(posedge sys_clk);
    // Disable on an accept boundary keeps the pending request out
    op(7'h20, 1'b1);
    #1 chk(busy_reg, 1'b0);
    rd_chk(4'h3, st(2'h0, 1'b0, 1'b0));
    op(7'h40, 1'b1);
    accept(3, 16'h0000);
    @(posedge sys_clk);
    irq_req <= 1'b0;
    vec <= 8'($random(seed));
    accept(4, 16'h0000);
    rd_chk(4'h0, 8'h07);
    reg_acc(1'b1, 4'h2, 8'h02, q);
    repeat (2) @(posedge sys_clk);
    #1 chk(irq_out, 1'b1);
    rd_chk(4'h2, 8'h02);
    reg_acc(1'b1, 4'h1, 8'h02, q);
    repeat (2) @(posedge sys_clk);
    #1 chk(irq_out, 1'b0);
    rd_chk(4'h0, 8'h05);
    rd_chk(4'h1, 8'h00);
    $display("test registers done");
    print_verdict();
  end
endmodule : cir_irq_unit_tb

// ### testbench/cir_periph_model.sv
/*
  Interrupting peripheral on a priority chain: raises the request and
  answers acknowledge with a byte. Assumes ack level from the unit.
*/
module cir_periph_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic req,
  input wire logic slow,
  input wire logic [7:0] vec,
  input wire logic ack,
  input wire logic ack_wait,
  output logic int_n,
  output logic [7:0] data_in
);
  logic settled;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      int_n <= 1'b1;
      settled <= 1'b0;
      data_in <= 8'hA5;
    end else begin
      int_n <= !req;
      if (ack_wait) begin
        settled <= 1'b1;
      end else if (!ack) begin
        settled <= 1'b0;
      end
      // Slow chain drives only after the waits; bus churns when undriven
      if (ack && (!slow || settled)) begin
        data_in <= vec;
      end else begin
        data_in <= ~data_in;
      end
    end
  end
endmodule : cir_periph_model
